// file: ptpsl_calc.sv
// PTP slave: timestamp capture, delay, offset and drift calculation
`timescale 1ns/1ps
module ptpsl_calc
  import ptpsl_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire ptpsl_rx_t        rx,
  input  wire logic             is_slave,
  input  wire logic             chassis_sync_leader,
  input  wire logic             tight_tol_req,
  input  wire logic             tx_ready,
  input  wire logic             tx_ts_valid,
  input  wire logic [TS_W-1:0]  tx_ts,
  output logic                  tx_req,
  output logic [SEQ_W-1:0]      tx_seq,
  output ptpsl_msg_t            rx_kind,
  output ptpsl_res_t            res,
  output logic                  lock_source_net,
  output logic [15:0]           tolerance_ns
);

  // ****************************************************************
  // Message decode
  // ****************************************************************
  ptpsl_regs_t q;
  ptpsl_regs_t d;
  logic        acc;
  logic        is_sync;
  logic        is_fup_match;
  logic        is_resp_match;

  // Recognise the five kinds
  always_comb begin
    case (rx.code)
      CODE_SYNC: begin
        rx_kind = PTPSL_MSG_SYNC;
      end
      CODE_DELAY_REQ: begin
        rx_kind = PTPSL_MSG_DELAY_REQ;
      end
      CODE_FOLLOW_UP: begin
        rx_kind = PTPSL_MSG_FOLLOW_UP;
      end
      CODE_DELAY_RESP: begin
        rx_kind = PTPSL_MSG_DELAY_RESP;
      end
      CODE_MGMT: begin
        rx_kind = PTPSL_MSG_MGMT;
      end
      default: begin
        rx_kind = PTPSL_MSG_OTHER;
      end
    endcase
  end

  // Only multicast frames while slave role is held
  // Slave role comes from the external best-master compare
  assign acc = rx.valid && rx.multicast && is_slave;

  // Accepted frames by kind; sequence ids pair the messages
  assign is_sync       = acc && (rx_kind == PTPSL_MSG_SYNC);
  assign is_fup_match  = acc && (rx_kind == PTPSL_MSG_FOLLOW_UP) && (rx.seq == q.sync_seq);
  assign is_resp_match = acc && (rx_kind == PTPSL_MSG_DELAY_RESP)
                         && (rx.seq == q.req_seq);

  // ****************************************************************
  // Signed delay and offset arithmetic
  // ****************************************************************
  // One bit of headroom keeps the halved sum exact
  logic signed [TS_W-1:0] ms;
  logic signed [TS_W-1:0] sm;
  logic signed [TS_W:0]   sum;
  logic signed [TS_W:0]   dif;

  always_comb begin
    ms  = $signed(q.t2) - $signed(q.t1);
    sm  = $signed(rx.origin_ts) - $signed(q.t3);
    sum = {ms[TS_W-1], ms} + {sm[TS_W-1], sm};
    dif = {ms[TS_W-1], ms} - {sm[TS_W-1], sm};
  end

  // ****************************************************************
  // Exchange sequencing
  // ****************************************************************
  always_comb begin
    d                 = q;
    d.req_pulse       = 1'b0;
    d.res.valid       = 1'b0;
    d.res.drift_valid = 1'b0;
    case (q.st)
      PTPSL_IDLE: begin
        // Wait for the next Sync
        if (is_sync) begin
          d.t2       = rx.rx_ts;
          d.sync_seq = rx.seq;
          d.st       = PTPSL_WAIT_FUP;
        end
      end
      PTPSL_WAIT_FUP: begin
        // A newer Sync replaces the pending one
        if (is_sync) begin
          d.t2       = rx.rx_ts;
          d.sync_seq = rx.seq;
        end else if (is_fup_match) begin
          d.t1 = rx.origin_ts;
          if (q.have_prev) begin
            d.res.slave_int   = q.t2 - q.prev_t2;
            d.res.master_int  = rx.origin_ts - q.prev_t1;
            d.res.drift_valid = 1'b1;
          end
          d.prev_t1   = rx.origin_ts;
          d.prev_t2   = q.t2;
          d.have_prev = 1'b1;
          d.req_seq   = q.req_seq + 16'h0001;
          d.st        = PTPSL_WAIT_TXTS;
        end
      end
      PTPSL_WAIT_TXTS: begin
        // Sync frames are ignored until t3 is known
        if (tx_ready) begin
          d.req_pulse = 1'b1;
        end
        if (tx_ts_valid) begin
          d.t3 = tx_ts;
          d.st = PTPSL_WAIT_RESP;
        end
      end
      PTPSL_WAIT_RESP: begin
        if (is_resp_match) begin
          d.res.delay  = sum[TS_W:1];
          d.res.offset = dif[TS_W:1];
          d.res.valid  = 1'b1;
          d.st         = PTPSL_IDLE;
        end else if (is_sync) begin
          // Lost response; restart from the new Sync
          d.t2       = rx.rx_ts;
          d.sync_seq = rx.seq;
          d.st       = PTPSL_WAIT_FUP;
        end
      end
      default: begin
        d.st = PTPSL_IDLE;
      end
    endcase
    // Losing the slave role drops any exchange in flight
    if (!is_slave) begin
      d.st = PTPSL_IDLE;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Request drops for one cycle once the MAC has taken it
  assign tx_req = (q.st == PTPSL_WAIT_TXTS) && !q.req_pulse;
  assign tx_seq = q.req_seq;
  assign res    = q.res;

  // Leader locks to network master
  assign lock_source_net = chassis_sync_leader;

  // Leader forces wide tolerance; tight only when not leader
  always_comb begin
    if (chassis_sync_leader) begin
      tolerance_ns = TOL_LEADER_NS;
    end else if (tight_tol_req) begin
      tolerance_ns = TOL_TIGHT_NS;
    end else begin
      tolerance_ns = TOL_LEADER_NS;
    end
  end

endmodule

// file: ptpsl_calc_checker.sv
// Port checker for the PTP slave calculator
`timescale 1ns/1ps
module ptpsl_calc_checker
  import ptpsl_pkg::*;
(
  input wire logic             clk,
  input wire logic             reset,
  input wire ptpsl_rx_t        rx,
  input wire logic             is_slave,
  input wire logic             chassis_sync_leader,
  input wire logic             tight_tol_req,
  input wire logic [SEQ_W-1:0] tx_seq,
  input wire ptpsl_msg_t       rx_kind,
  input wire ptpsl_res_t       res,
  input wire logic             lock_source_net,
  input wire logic [15:0]      tolerance_ns
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ****
  // Relations
  // ****
  chk_tol_leader: assert property (chassis_sync_leader |-> tolerance_ns == 16'h3e8)
    else $error("leader tolerance");
  chk_tol_tight: assert property (
    tight_tol_req && !chassis_sync_leader |-> tolerance_ns == 16'h96) else $error("tight");
  chk_lock_net: assert property (lock_source_net == chassis_sync_leader)
    else $error("lock source");
  chk_kind_mgmt: assert property (rx.code == CODE_MGMT |-> rx_kind == PTPSL_MSG_MGMT)
    else $error("mgmt decode");
  chk_kind_fup: assert property (rx.code == 4'h8 |-> rx_kind == PTPSL_MSG_FOLLOW_UP)
    else $error("follow-up decode");
  chk_res_cause: assert property (res.valid |-> $past(rx.valid && rx.code == 4'h9))
    else $error("result without response");
  chk_res_seq: assert property (res.valid |-> $past(rx.seq) == tx_seq)
    else $error("result seq");
  chk_refuse_frame: assert property (
    rx.valid && !(rx.multicast && is_slave) |=> !res.valid) else $error("refused frame");
  chk_drift_fup: assert property (res.drift_valid |-> $past(rx.code) == 4'h8)
    else $error("drift cause");
  cover property (res.valid);
  cover property (res.drift_valid);
  cover property (chassis_sync_leader && tight_tol_req);
endmodule

// file: ptpsl_calc_tb.sv
// Self-checking bench for the PTP slave calculator
`timescale 1ns/1ps
module ptpsl_calc_tb
  import ptpsl_pkg::*;
;
  logic clk, reset, is_slave, chassis_sync_leader, tight_tol_req, tx_req, tx_ready, tx_ts_valid;
  logic [TS_W-1:0] tx_ts;
  logic [SEQ_W-1:0] tx_seq;
  ptpsl_rx_t rx;
  ptpsl_res_t res;
  logic [15:0] tolerance_ns;
  logic lock_source_net;
  int failures, checks;
  logic [31:0] rnd;
  logic [128:0] expq[$];
  longint p1, p2;
  bit hp, seen;
  ptpsl_calc ptpsl_calc_i (.clk, .reset, .rx, .is_slave, .chassis_sync_leader, .tight_tol_req,
    .tx_ready, .tx_ts_valid, .tx_ts, .tx_req, .tx_seq, .rx_kind(), .res, .lock_source_net,
    .tolerance_ns);
  ptpsl_master_model ptpsl_master_model_i (.clk, .tx_req, .rx, .tx_ready, .tx_ts_valid, .tx_ts);
  // ****
  // Helpers
  // ****
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  function automatic longint xs();
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return longint'(rnd[23:0]);
  endfunction
  task automatic cmp(input logic ok, input string what);
    checks++;
    if (ok !== 1'b1) begin
      failures++;
      $display("Error at %0t: %s", $time, what);
    end
  endtask
  task automatic test_done();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(negedge clk) begin
    if (!reset && (res.valid || res.drift_valid)) begin
      cmp(expq.size() > 0 && expq.pop_front() === (res.valid ? {1'b1, res.delay, res.offset} :
        {1'b0, res.slave_int, res.master_int}), "result");
    end
  end
  task automatic xchg(input logic [SEQ_W-1:0] s, input bit bad);
    longint t1, t2, t3, t4;
    t1 = xs() << 16;
    t2 = t1 + xs() % 4096 - 2048;
    t3 = t2 + 900;
    t4 = t3 + xs() % 4096 - 2048;
    if (hp) expq.push_back({1'b0, 64'(t2 - p2), 64'(t1 - p1)});
    hp = 1'b1;
    p1 = t1;
    p2 = t2;
    ptpsl_master_model_i.send(CODE_SYNC, s, 1'b1, 64'(~t1), 64'(t2));
    ptpsl_master_model_i.send(CODE_FOLLOW_UP, s, 1'b1, 64'(t1), 64'(~t2));
    ptpsl_master_model_i.serve(64'(t3), int'(xs() % 4), seen);
    cmp(seen, "no delay request");
    if (!seen) test_done();
    if (bad) ptpsl_master_model_i.send(CODE_DELAY_RESP, ~tx_seq, 1'b1, 64'(t4 + 5), '0);
    if (bad) ptpsl_master_model_i.send(CODE_DELAY_RESP, tx_seq, 1'b0, 64'(t4 + 9), '0);
    expq.push_back({1'b1, 64'((t2 - t1 + t4 - t3) >>> 1), 64'((t2 - t1 - t4 + t3) >>> 1)});
    ptpsl_master_model_i.send(CODE_DELAY_RESP, tx_seq, 1'b1, 64'(t4), '0);
    repeat (3) @(posedge clk);
  endtask
  // ****
  // Sequence
  // ****
  initial begin
    rnd = 32'h3d;
    reset = 1'b1;
    is_slave = 1'b1;
    chassis_sync_leader = 1'b0;
    tight_tol_req = 1'b0;
    repeat (2) @(posedge clk);
    cmp(res === '0 && tx_req === 1'b0, "reset state");
    reset <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      chassis_sync_leader <= i[1];
      tight_tol_req <= i[0];
      @(negedge clk);
      cmp(tolerance_ns === (i == 1 ? 16'h96 : 16'h3e8), "tolerance");
      cmp(lock_source_net === i[1], "lock source");
    end
    ptpsl_master_model_i.send(CODE_MGMT, 16'h0, 1'b1, '0, '0);
    ptpsl_master_model_i.send(CODE_DELAY_REQ, 16'h0, 1'b1, '0, '0);
    for (int n = 0; n < 6; n++) xchg(16'(xs()), n[0]);
    $display("exchanges done");
    is_slave <= 1'b0;
    ptpsl_master_model_i.send(CODE_SYNC, 16'h5, 1'b1, '0, '0);
    ptpsl_master_model_i.send(CODE_FOLLOW_UP, 16'h5, 1'b1, '0, '0);
    repeat (4) @(negedge clk) cmp(tx_req === 1'b0, "request when not slave");
    cmp(expq.size() == 0, "missing result");
    test_done();
  end
endmodule
bind ptpsl_calc ptpsl_calc_checker ptpsl_calc_checker_i (.clk(clk), .reset(reset), .rx(rx),
  .is_slave(is_slave), .chassis_sync_leader(chassis_sync_leader), .tight_tol_req(tight_tol_req),
  .tx_seq(tx_seq), .rx_kind(rx_kind), .res(res), .lock_source_net(lock_source_net),
  .tolerance_ns(tolerance_ns));

// file: ptpsl_master_model.sv
// Master clock model for the PTP slave calculator
`timescale 1ns/1ps
module ptpsl_master_model
  import ptpsl_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       tx_req,
  output ptpsl_rx_t       rx,
  output logic            tx_ready,
  output logic            tx_ts_valid,
  output logic [TS_W-1:0] tx_ts
);
  // ****
  // Frames and request acceptance
  // ****
  initial begin
    rx = '0;
    tx_ready = 1'b0;
    tx_ts_valid = 1'b0;
    tx_ts = '0;
  end
  // One-cycle frame with multicast flag m, inverted once released
  task automatic send(input logic [3:0] c, input logic [SEQ_W-1:0] s, input logic m,
                      input logic [TS_W-1:0] o, input logic [TS_W-1:0] r);
    @(posedge clk);
    rx <= '{1'b1, c, s, m, o, r};
    @(posedge clk);
    rx <= '{1'b0, ~c, ~s, ~m, ~o, ~r};
  endtask
  task automatic serve(input logic [TS_W-1:0] t3, input int stall, output bit seen);
    seen = 1'b0;
    for (int i = 0; i < 50 && !seen; i++) begin
      @(negedge clk);
      seen = tx_req;
    end
    repeat (stall + 1) @(posedge clk);
    tx_ready <= 1'b1;
    @(posedge clk);
    tx_ready <= 1'b0;
    tx_ts_valid <= 1'b1;
    tx_ts <= t3;
    @(posedge clk);
    tx_ts_valid <= 1'b0;
    tx_ts <= ~t3;
  endtask
endmodule

// file: ptpsl_pkg.sv
// Package for the PTP slave offset and delay calculator
package ptpsl_pkg;

  // ****************************************************************
  // Widths and message kinds
  // ****************************************************************
  localparam int TS_W  = 64;
  localparam int SEQ_W = 16;

  typedef enum logic [2:0] {
    PTPSL_MSG_SYNC       = 3'h0,
    PTPSL_MSG_DELAY_REQ  = 3'h1,
    PTPSL_MSG_FOLLOW_UP  = 3'h2,
    PTPSL_MSG_DELAY_RESP = 3'h3,
    PTPSL_MSG_MGMT       = 3'h4,
    PTPSL_MSG_OTHER      = 3'h7
  } ptpsl_msg_t;

  // Wire codes of the message type nibble
  localparam logic [3:0] CODE_SYNC       = 4'h0;
  localparam logic [3:0] CODE_DELAY_REQ  = 4'h1;
  localparam logic [3:0] CODE_FOLLOW_UP  = 4'h8;
  localparam logic [3:0] CODE_DELAY_RESP = 4'h9;
  localparam logic [3:0] CODE_MGMT       = 4'hd;

  // Lock tolerances in ns
  localparam logic [15:0] TOL_LEADER_NS = 16'd1000;
  localparam logic [15:0] TOL_TIGHT_NS  = 16'd150;

  typedef enum logic [1:0] {
    PTPSL_IDLE      = 2'b00,
    PTPSL_WAIT_FUP  = 2'b01,
    PTPSL_WAIT_TXTS = 2'b10,
    PTPSL_WAIT_RESP = 2'b11
  } ptpsl_state_t;

  // Received message from the MAC side
  typedef struct packed {
    logic              valid;
    logic [3:0]        code;
    logic [SEQ_W-1:0]  seq;
    logic              multicast;
    logic [TS_W-1:0]   origin_ts;
    logic [TS_W-1:0]   rx_ts;
  } ptpsl_rx_t;

  // Results toward the clock servo
  typedef struct packed {
    logic              valid;
    logic [TS_W-1:0]   delay;
    logic [TS_W-1:0]   offset;
    logic [TS_W-1:0]   slave_int;
    logic [TS_W-1:0]   master_int;
    logic              drift_valid;
  } ptpsl_res_t;

  typedef struct packed {
    ptpsl_state_t      st;
    logic [TS_W-1:0]   t1;
    logic [TS_W-1:0]   t2;
    logic [TS_W-1:0]   t3;
    logic [TS_W-1:0]   prev_t1;
    logic [TS_W-1:0]   prev_t2;
    logic              have_prev;
    logic [SEQ_W-1:0]  sync_seq;
    logic [SEQ_W-1:0]  req_seq;
    logic              req_pulse;
    ptpsl_res_t        res;
  } ptpsl_regs_t;

endpackage
